/* pkg/actc_defines.svh */
// Purpose: constants for the conversion trigger control
// Assumes: 20 MHz system clock
// Notes: sequence mode codes follow the two-bit mode field
`ifndef ACTC_DEFINES_SVH
`define ACTC_DEFINES_SVH
`define ACTC_SEQ_SINGLE 2'h0
`define ACTC_SEQ_SEQUENCE 2'h1
`define ACTC_SEQ_REPEAT_SINGLE 2'h2
`define ACTC_SEQ_REPEAT_SEQUENCE 2'h3
`define ACTC_SAMPLE_CYCLES 8'h04
`define ACTC_CONVERT_CYCLES 8'h0d
`define ACTC_CHAN_W 4
`define ACTC_REV_ID 8'h5a
`endif

/* pkg/actc_pkg.sv */
// Purpose: types for the conversion trigger control
// Assumes: nothing beyond the defines header
// Notes: one-hot state codes
package actc_pkg;
  typedef enum logic [3:0] {
    ACTC_IDLE = 4'b0001,
    ACTC_SAMPLE = 4'b0010,
    ACTC_CONVERT = 4'b0100,
    ACTC_HALT = 4'b1000
  } actc_state_t;
endpackage

/* src/actc_timer.sv */
// Purpose: phase counter for sample and convert intervals
// Assumes: start pulses only when idle
// Notes: done is a one-cycle pulse
`timescale 1ns/1ps
module actc_timer #(
  parameter logic [7:0] LEN = 8'h01
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic start,
  output logic done
);
  typedef struct packed {
    logic [7:0] cnt;
    logic run;
    logic done;
  } actc_tmr_t;
  actc_tmr_t st_ff;
  actc_tmr_t nxt_st;
  always_comb begin
    nxt_st = st_ff;
    nxt_st.done = 1'b0;
    if (start) begin
      nxt_st.run = 1'b1;
      nxt_st.cnt = 8'h00;
    end else if (st_ff.run) begin
      nxt_st.cnt = st_ff.cnt + 8'h01;
      if (st_ff.cnt + 8'h01 == LEN) begin
        nxt_st.run = 1'b0;
        nxt_st.done = 1'b1;
      end
    end
  end
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
  assign done = st_ff.done;
endmodule

/* src/actc_ctrl.sv */
// Purpose: conversion trigger and sequencing control
// Assumes: control register bits arrive as plain ports, writes flagged by a strobe
// Notes: reproduces the two trigger faults on purpose
// Operation
// [RULE_01] in timer mode with single mode, any control0 write starts a new sample.
// [RULE_02] software clears enable before other control0 changes in that mode, then sets it.
// [RULE_03] conversions start from the software trigger or a timer output per pulse mode.
// [RULE_04] in sequence and repeat modes a trigger while busy halts later conversions.
// [RULE_05] the overflow flag is unreliable and must not be trusted for overrun.
// [RULE_06] software polls busy before issuing a manual trigger.
// [RULE_07] the timer period must exceed sample plus conversion time.
// [RULE_08] recovery clears enable and power, then sets both, then retriggers.
// [RULE_09] busy rises at sample start and falls when the last result is stored.
`timescale 1ns/1ps
`include "actc_defines.svh"
module actc_ctrl
  import actc_pkg::*;
#(
  parameter int CHAN_W = `ACTC_CHAN_W
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic ctl0Write,
  input wire logic converterPowerOn,
  input wire logic enableConversionBit,
  input wire logic softwareSampleTrigger,
  input wire logic samplePulseMode,
  input wire logic [1:0] conversionSequenceField,
  input wire logic [CHAN_W-1:0] lastChannel,
  input wire logic timerTrigger,
  output logic conversionBusyFlag,
  output logic convTimeOverflowFlag,
  output logic convHalted,
  output logic resultStore,
  output logic [CHAN_W-1:0] resultChannel,
  output logic [7:0] hardwareRevisionId
);
  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    actc_state_t state;
    logic [CHAN_W-1:0] chan;
    logic trgSync1;
    logic trgSync2;
    logic trgPrev;
    logic encPrev;
    logic tov;
    logic store;
    logic [CHAN_W-1:0] resChan;
  } actc_st_t;
  actc_st_t st_ff;
  actc_st_t nxt_st;
  logic sampleDone;
  logic convDone;
  logic timerEdge;
  logic trigger;
  logic repeatMode;
  logic seqMode;
  logic startSample;
  ////////////////////////////////////////////////////////////////////////////
  actc_timer #(.LEN(`ACTC_SAMPLE_CYCLES)) uSample (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .start(startSample),
    .done(sampleDone)
  );
  actc_timer #(.LEN(`ACTC_CONVERT_CYCLES)) uConvert (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .start(sampleDone),
    .done(convDone)
  );
  ////////////////////////////////////////////////////////////////////////////
  // timer pin is foreign: two flops before the edge detector
  assign timerEdge = st_ff.trgSync2 & ~st_ff.trgPrev;
  assign trigger = converterPowerOn & enableConversionBit &
    (samplePulseMode ? timerEdge : softwareSampleTrigger); // [RULE_03]
  assign repeatMode = conversionSequenceField == `ACTC_SEQ_REPEAT_SINGLE ||
    conversionSequenceField == `ACTC_SEQ_REPEAT_SEQUENCE;
  assign seqMode = conversionSequenceField == `ACTC_SEQ_SEQUENCE ||
    conversionSequenceField == `ACTC_SEQ_REPEAT_SEQUENCE;
  always_comb begin
    nxt_st = st_ff;
    nxt_st.trgSync1 = timerTrigger;
    nxt_st.trgSync2 = st_ff.trgSync1;
    nxt_st.trgPrev = st_ff.trgSync2;
    nxt_st.encPrev = enableConversionBit;
    nxt_st.store = 1'b0;
    nxt_st.tov = 1'b0; // [RULE_05] never set by an overrun, by design of the fault
    startSample = 1'b0;
    unique case (st_ff.state)
      ACTC_IDLE: begin
        nxt_st.chan = '0;
        // fault kept: control0 write acts like an arm in timer single mode
        if (trigger || (ctl0Write && samplePulseMode && converterPowerOn &&
            enableConversionBit &&
            conversionSequenceField == `ACTC_SEQ_SINGLE)) begin // [RULE_01]
          nxt_st.state = ACTC_SAMPLE; // [RULE_09]
          startSample = 1'b1;
        end
      end
      ACTC_SAMPLE, ACTC_CONVERT: begin
        if (trigger && conversionSequenceField != `ACTC_SEQ_SINGLE) begin
          nxt_st.state = ACTC_HALT; // [RULE_04]
        end else if (!converterPowerOn) begin
          nxt_st.state = ACTC_IDLE;
        // phase timers keep running after an abort: only take the done of this phase
        end else if (st_ff.state == ACTC_SAMPLE && sampleDone) begin
          nxt_st.state = ACTC_CONVERT;
        end else if (st_ff.state == ACTC_CONVERT && convDone) begin
          nxt_st.store = 1'b1;
          nxt_st.resChan = st_ff.chan;
          if (seqMode && st_ff.chan != lastChannel) begin
            nxt_st.chan = st_ff.chan + 1'b1;
            nxt_st.state = ACTC_SAMPLE;
            startSample = 1'b1;
          end else if (repeatMode && enableConversionBit) begin
            nxt_st.chan = '0;
            nxt_st.state = ACTC_SAMPLE;
            startSample = 1'b1;
          end else begin
            nxt_st.state = ACTC_IDLE; // [RULE_09]
          end
        end
      end
      ACTC_HALT: begin
        // only full power and enable drop clears the stall
        if (!converterPowerOn && !enableConversionBit) begin
          nxt_st.state = ACTC_IDLE; // [RULE_08]
        end
      end
    endcase
  end
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      st_ff <= '{state: ACTC_IDLE, default: '0};
    end else begin
      st_ff <= nxt_st;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  assign conversionBusyFlag = st_ff.state == ACTC_SAMPLE || st_ff.state == ACTC_CONVERT;
  assign convTimeOverflowFlag = st_ff.tov;
  assign convHalted = st_ff.state == ACTC_HALT;
  assign resultStore = st_ff.store;
  assign resultChannel = st_ff.resChan;
  assign hardwareRevisionId = `ACTC_REV_ID; // arbitrary value
  ////////////////////////////////////////////////////////////////////////////
  sequence haltCause_s;
    conversionBusyFlag && trigger && conversionSequenceField != `ACTC_SEQ_SINGLE;
  endsequence
  sequence staysHalted_s;
    convHalted [*2];
  endsequence
  sequence singleRetrig_s;
    conversionBusyFlag && trigger && conversionSequenceField == `ACTC_SEQ_SINGLE;
  endsequence
  write_starts_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (st_ff.state == ACTC_IDLE && ctl0Write && samplePulseMode && converterPowerOn
     && enableConversionBit && conversionSequenceField == `ACTC_SEQ_SINGLE)
    |=> conversionBusyFlag) // [RULE_01]
    else $error("control0 write did not start a sample");
  manual_trig_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (st_ff.state == ACTC_IDLE && !samplePulseMode && softwareSampleTrigger &&
     converterPowerOn && enableConversionBit) |=> conversionBusyFlag) // [RULE_03]
    else $error("manual trigger ignored");
  halt_entry_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    haltCause_s |=> convHalted) // [RULE_04]
    else $error("busy trigger did not halt");
  halt_holds_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (convHalted && converterPowerOn) |=> staysHalted_s or !converterPowerOn) // [RULE_04]
    else $error("halt left without recovery");
  tov_quiet_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    haltCause_s |-> ##1 !convTimeOverflowFlag) // [RULE_05]
    else $error("overflow flag raised");
  recover_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (convHalted && !converterPowerOn && !enableConversionBit) |=> !convHalted) // [RULE_08]
    else $error("recovery did not clear halt");
  busy_span_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (resultStore && !conversionBusyFlag) |-> $past(conversionBusyFlag)) // [RULE_09]
    else $error("busy fell before store");
  sample_len_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    ($rose(conversionBusyFlag) && converterPowerOn) |-> ##1
      (st_ff.state == ACTC_SAMPLE || !conversionBusyFlag || convHalted)[*3]) // [RULE_09]
    else $error("sample phase too short");
  ////////////////////////////////////////////////////////////////////////////
  // single mode tolerates a retrigger: the fault only hits the other modes
  single_ignore_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    singleRetrig_s
    |=> !convHalted) // [RULE_04]
    else $error("single mode retrigger halted");
  halt_no_store_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    convHalted
    |-> !resultStore) // [RULE_04]
    else $error("result stored while halted");
  power_gate_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    !converterPowerOn
    |=> !conversionBusyFlag) // [RULE_03]
    else $error("busy with converter off");
  enable_gate_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (st_ff.state == ACTC_IDLE && !enableConversionBit)
    |=> !conversionBusyFlag) // [RULE_01]
    else $error("start without enable");
  manual_write_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (st_ff.state == ACTC_IDLE && !samplePulseMode && !softwareSampleTrigger && ctl0Write)
    |=> !conversionBusyFlag) // [RULE_01]
    else $error("control0 write started in manual mode");
  single_end_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (resultStore && $past(conversionSequenceField) == `ACTC_SEQ_SINGLE)
    |-> !conversionBusyFlag) // [RULE_09]
    else $error("busy held after single result");
  // a sequence only ends with a store once the last channel has been stored
  seq_last_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (resultStore && !conversionBusyFlag && $past(seqMode))
    |-> resultChannel == $past(lastChannel)) // [RULE_09]
    else $error("sequence ended before last channel");
endmodule

/* sim/tb.sv */
// Purpose: self-checking bench for the conversion trigger control
// Assumes: inputs change 1 ns after the rising edge
// Notes: long conversions keep the table short; repeat modes only in the halt test
`timescale 1ns/1ps
`include "actc_defines.svh"
module tb;
  logic clk_sys, rstn, ctl0Write, converterPowerOn, enableConversionBit;
  logic softwareSampleTrigger, samplePulseMode, timerTrigger;
  logic [1:0] conversionSequenceField;
  logic [3:0] lastChannel, resultChannel, lastSeen;
  logic conversionBusyFlag, convTimeOverflowFlag, convHalted, resultStore;
  logic [7:0] hardwareRevisionId;
  int mismatches = 0, checked = 0, stores;
  // rows: mode, last channel, stores expected, final channel
  logic [15:0] rows [4] = '{16'h0_0_1_0, 16'h0_5_1_0, 16'h1_2_3_2, 16'h1_0_1_0};
  actc_ctrl u_actc_ctrl (.clk_sys(clk_sys), .rstn(rstn), .ctl0Write(ctl0Write),
    .converterPowerOn(converterPowerOn), .enableConversionBit(enableConversionBit),
    .softwareSampleTrigger(softwareSampleTrigger), .samplePulseMode(samplePulseMode),
    .conversionSequenceField(conversionSequenceField), .lastChannel(lastChannel),
    .timerTrigger(timerTrigger), .conversionBusyFlag(conversionBusyFlag),
    .convTimeOverflowFlag(convTimeOverflowFlag), .convHalted(convHalted),
    .resultStore(resultStore), .resultChannel(resultChannel),
    .hardwareRevisionId(hardwareRevisionId));
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one-cycle pulse on a trigger input, then up to 4 cycles for busy
  task automatic pulse(ref logic sig, input logic expBusy);
    sig = 1'b1;
    step(1);
    sig = 1'b0;
    repeat (4) if (conversionBusyFlag !== 1'b1) step(1);
    chk(conversionBusyFlag, expBusy);
  endtask
  // count stores until busy drops, bounded
  task automatic drain();
    stores = 0;
    for (int i = 0; i < 300 && conversionBusyFlag === 1'b1; i++) begin
      step(1);
      if (resultStore === 1'b1) begin
        stores++;
        lastSeen = resultChannel;
      end
    end
    chk(conversionBusyFlag, 8'h00);
  endtask
  task automatic summarize();
    $display("checked=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #(5000 * 50);
    mismatches++;
    summarize();
  end
  initial begin
    {rstn, ctl0Write, softwareSampleTrigger, samplePulseMode, timerTrigger} = '0;
    {converterPowerOn, enableConversionBit} = 2'b11;
    conversionSequenceField = 2'h0;
    lastChannel = 4'h0;
    step(6);
    rstn = 1'b1;
    chk({convHalted, resultStore, conversionBusyFlag}, 8'h00);
    chk(hardwareRevisionId, `ACTC_REV_ID);
    $display("test reset done");
    foreach (rows[r]) begin
      conversionSequenceField = rows[r][13:12];
      lastChannel = rows[r][11:8];
      pulse(softwareSampleTrigger, 1'b1);
      drain();
      chk(stores, rows[r][7:4]);
      chk(lastSeen, rows[r][3:0]);
      $display("test row %0d done", r);
    end
    // timer mode, single: any control0 write arms a sample, only with enable set
    samplePulseMode = 1'b1;
    conversionSequenceField = 2'h0;
    pulse(ctl0Write, 1'b1);
    drain();
    enableConversionBit = 1'b0;
    pulse(ctl0Write, 1'b0);
    enableConversionBit = 1'b1;
    step(1);
    chk(conversionBusyFlag, 8'h00);
    timerTrigger = 1'b1;
    step(2);
    pulse(timerTrigger, 1'b1);
    drain();
    samplePulseMode = 1'b0;
    pulse(ctl0Write, 1'b0);
    $display("test trigger sources done");
    // single mode ignores a retrigger while busy
    pulse(softwareSampleTrigger, 1'b1);
    pulse(softwareSampleTrigger, 1'b1);
    chk(convHalted, 8'h00);
    drain();
    for (int m = 1; m < 4; m++) begin
      conversionSequenceField = m[1:0];
      lastChannel = 4'h3;
      pulse(softwareSampleTrigger, 1'b1);
      step(2);
      softwareSampleTrigger = 1'b1;
      step(2);
      softwareSampleTrigger = 1'b0;
      step(2);
      chk(convHalted, 8'h01);
      stores = 0;
      repeat (60) begin
        step(1);
        if (resultStore === 1'b1) stores++;
      end
      chk(stores, 0);
      chk(convTimeOverflowFlag, 8'h00);
      {converterPowerOn, enableConversionBit} = 2'b00;
      step(3);
      chk(convHalted, 8'h00);
      {converterPowerOn, enableConversionBit} = 2'b11;
      step(1);
      conversionSequenceField = 2'h1;
      pulse(softwareSampleTrigger, 1'b1);
      drain();
      chk(stores, 4);
      $display("test halt mode %0d done", m);
    end
    summarize();
  end
endmodule
